//--- src/dimming_pkg.sv
package dimming_pkg;

  // =====================================================================
  // geometry
  localparam int CHANNELS   = 10;
  localparam int PERIOD_W   = 13;
  localparam int ON_W       = 16;
  localparam int CUR_W      = 6;
  localparam int CNT_W      = 17;

  // =====================================================================
  // timing
  localparam int CLK_PERIOD_NS    = 8;
  localparam int ON_STEP_NS       = 150;
  localparam int FRAME_UNIT_NS    = 1500;
  localparam int MIN_ON_NS        = 1000;
  localparam int SYNC_LOSS_NS     = 6000;
  localparam int FRAME_UNIT_STEPS = FRAME_UNIT_NS / ON_STEP_NS;
  localparam int MIN_ON_STEPS     = (MIN_ON_NS + ON_STEP_NS - 1) / ON_STEP_NS;
  localparam int SYNC_LOSS_CYC    = SYNC_LOSS_NS / CLK_PERIOD_NS;
  localparam int DITHER_LEN       = 46;
  localparam logic [DITHER_LEN-1:0] DITHER_PATTERN = 46'h2C59_A3E1_B74;

  // =====================================================================
  // register map
  localparam logic [7:0] REG_EN_LO    = 8'h00;
  localparam logic [7:0] REG_EN_HI    = 8'h01;
  localparam logic [7:0] REG_LIVE_LO  = 8'h02;
  localparam logic [7:0] REG_LIVE_HI  = 8'h03;
  localparam logic [7:0] REG_DITHER   = 8'h05;
  localparam logic [7:0] REG_PER_LO   = 8'h06;
  localparam logic [7:0] REG_PER_HI   = 8'h07;
  localparam logic [7:0] REG_JOIN_LO  = 8'h08;
  localparam logic [7:0] REG_JOIN_HI  = 8'h09;
  localparam logic [7:0] REG_ON_FIRST = 8'h10;
  localparam logic [7:0] REG_ON_LAST  = 8'h23;
  localparam logic [7:0] REG_CUR_BASE = 8'h30;
  localparam int         HI_BITS      = 2;
  localparam int         PER_HI_BITS  = 5;
  localparam int         SPREAD_W     = 2;

  // arbitrary bus address, not tied to any product
  localparam logic [6:0] DEV_ADDR = 7'h2A;

  typedef enum logic [8:0] {
    I_IDLE = 9'h001,
    I_ADDR = 9'h002,
    I_ACKA = 9'h004,
    I_REG  = 9'h008,
    I_ACKR = 9'h010,
    I_WR   = 9'h020,
    I_ACKW = 9'h040,
    I_RD   = 9'h080,
    I_RACK = 9'h100
  } bus_e;

  typedef logic [CHANNELS-1:0][CUR_W-1:0] current_t;

  typedef struct packed {
    logic                active;
    logic                high;
    logic [SPREAD_W-1:0] spread_index_field;
  } dither_s;

  typedef struct packed {
    bus_e                           ist;
    logic [3:0]                     bitcnt;
    logic [7:0]                     shreg;
    logic [7:0]                     ptr;
    logic                           rw;
    logic                           sda_oe;
    logic                           sda_lvl;
    logic [2:0]                     scl_sy;
    logic [2:0]                     sda_sy;
    logic [7:0]                     en_lo;
    logic [7:0]                     en_hi;
    logic [7:0]                     dith;
    logic [7:0]                     join_lo;
    logic [7:0]                     join_hi;
    logic [7:0]                     per_lo;
    logic [7:0]                     per_hi;
    logic [CHANNELS-1:0][ON_W-1:0]  on_t;
    current_t                       cur;
    logic [PERIOD_W-1:0]            sh_per;
    logic [CHANNELS-1:0][ON_W-1:0]  sh_on;
    logic [CHANNELS-1:0]            sh_en;
    logic [CHANNELS-1:0]            sh_join;
    logic [7:0]                     acc;
    logic                           step;
    logic                           wrap;
    logic [CNT_W-1:0]               cnt;
    logic [CHANNELS-1:0]            sink;
    logic [2:0]                     fsy;
    logic [2:0]                     osc;
    logic [9:0]                     sync_cnt;
    logic                           half;
    logic                           adv;
    logic [5:0]                     idx;
    dither_s                        dith_o;
  } state_s;

  // bus pins idle high, so their synchronisers start high and no false edge follows reset
  localparam state_s STATE_RST = '{ist: I_IDLE, scl_sy: 3'h7, sda_sy: 3'h7, default: '0};

endpackage

//--- src/polyphase_dimming.sv
module polyphase_dimming
  import dimming_pkg::*;
(
  input  wire logic                     core_clk_in,
  input  wire logic                     reset_n_in,
  input  wire logic                     scl_in,
  input  wire logic                     sda_in,
  output logic                          sda_out,
  output logic                          sda_oe_out,
  input  wire logic                     freq_set_sync_pin_in,
  input  wire logic                     sw_osc_in,
  output logic [dimming_pkg::CHANNELS-1:0] string_sink_pin_out,
  output dimming_pkg::current_t         sink_current_out,
  output dimming_pkg::dither_s          dither_out
);
  import dimming_pkg::*;

  state_s            s;
  state_s            n;
  logic              rst_n;
  logic [1:0]        rst_sy_q;
  logic              scl_r;
  logic              scl_f;
  logic              start;
  logic              stop;
  logic              osc_rise;
  logic [CNT_W-1:0]  frame_len;
  logic [CNT_W-1:0]  slot;
  logic [CNT_W-1:0]  start_k;
  logic [CNT_W-1:0]  diff;
  logic [CNT_W-1:0]  eff_on;
  logic [CHANNELS-1:0][3:0] lead;
  logic [7:0]        rd_byte;

  // =====================================================================
  // register decode
  function automatic logic on_hit(input logic [7:0] a);
    return (a >= REG_ON_FIRST) && (a <= REG_ON_LAST);
  endfunction

  function automatic logic [3:0] on_chan(input logic [7:0] a);
    logic [7:0] off;
    off = a - REG_ON_FIRST;
    return off[4:1];
  endfunction

  function automatic logic cur_hit(input logic [7:0] a);
    return (a >= REG_CUR_BASE) && (a < REG_CUR_BASE + 8'(CHANNELS));
  endfunction

  function automatic logic [7:0] reg_read(input state_s st, input logic [7:0] a);
    logic [7:0] r;
    r = '0;
    if (on_hit(a)) begin
      r = a[0] ? st.on_t[on_chan(a)][7:0] : st.on_t[on_chan(a)][15:8];
    end else if (cur_hit(a)) begin
      r = {2'h0, st.cur[4'(a - REG_CUR_BASE)]};
    end else begin
      case (a)
        REG_EN_LO:   r = st.en_lo;
        REG_EN_HI:   r = {6'h00, st.en_hi[HI_BITS-1:0]};
        REG_LIVE_LO: r = st.sink[7:0];
        REG_LIVE_HI: r = {6'h00, st.sink[CHANNELS-1:8]};
        REG_DITHER:  r = {6'h00, st.dith[SPREAD_W-1:0]};
        REG_PER_LO:  r = st.per_lo;
        REG_PER_HI:  r = {3'h0, st.per_hi[PER_HI_BITS-1:0]};
        REG_JOIN_LO: r = st.join_lo;
        REG_JOIN_HI: r = {6'h00, st.join_hi[HI_BITS-1:0]};
        default:     r = '0;
      endcase
    end
    return r;
  endfunction

  // =====================================================================
  // reset release
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_sy_q <= '0;
    end else begin
      rst_sy_q <= {rst_sy_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sy_q[1];

  // =====================================================================
  // next state
  always_comb begin
    n = s;
    rd_byte = '0;
    frame_len = '0;
    slot = '0;
    start_k = '0;
    diff = '0;
    eff_on = '0;
    lead = '0;
    n.scl_sy = {s.scl_sy[1:0], scl_in};
    n.sda_sy = {s.sda_sy[1:0], sda_in};
    scl_r = s.scl_sy[1] & ~s.scl_sy[2];
    scl_f = ~s.scl_sy[1] & s.scl_sy[2];
    start = s.scl_sy[1] & s.scl_sy[2] & s.sda_sy[2] & ~s.sda_sy[1];
    stop  = s.scl_sy[1] & s.scl_sy[2] & ~s.sda_sy[2] & s.sda_sy[1];

    // serial slave; writes land any time; period, on-times, enables and joins reach the engine only at frame wrap, currents and dither act at once
    if (start) begin
      n.ist = I_ADDR;
      n.bitcnt = '0;
      n.sda_oe = 1'b0;
    end else if (stop) begin
      n.ist = I_IDLE;
      n.sda_oe = 1'b0;
    end else if (scl_r) begin
      case (s.ist)
        I_ADDR, I_REG, I_WR: begin
          n.shreg = {s.shreg[6:0], s.sda_sy[1]};
          n.bitcnt = s.bitcnt + 4'h1;
        end
        I_RD: begin
          n.bitcnt = s.bitcnt + 4'h1;
        end
        I_RACK: begin
          if (s.sda_sy[1]) begin
            n.ist = I_IDLE;
          end
        end
        default: n.ist = s.ist;
      endcase
    end else if (scl_f) begin
      case (s.ist)
        I_ADDR: begin
          if (s.bitcnt == 4'h8) begin
            if (s.shreg[7:1] == DEV_ADDR) begin
              n.ist = I_ACKA;
              n.sda_oe = 1'b1;
              n.rw = s.shreg[0];
            end else begin
              n.ist = I_IDLE;
            end
          end
        end
        I_ACKA: begin
          n.bitcnt = '0;
          n.sda_oe = 1'b0;
          n.ist = I_REG;
          if (s.rw) begin
            rd_byte = reg_read(s, s.ptr);
            n.shreg = rd_byte;
            n.sda_oe = ~rd_byte[7];
            n.ist = I_RD;
          end
        end
        I_REG: begin
          if (s.bitcnt == 4'h8) begin
            n.ptr = s.shreg;
            n.ist = I_ACKR;
            n.sda_oe = 1'b1;
          end
        end
        I_ACKR, I_ACKW: begin
          n.sda_oe = 1'b0;
          n.bitcnt = '0;
          n.ist = I_WR;
        end
        I_WR: begin
          if (s.bitcnt == 4'h8) begin
            n.ptr = s.ptr + 8'h01;
            n.ist = I_ACKW;
            n.sda_oe = 1'b1;
            if (on_hit(s.ptr)) begin
              if (s.ptr[0]) begin
                n.on_t[on_chan(s.ptr)][7:0] = s.shreg;
              end else begin
                n.on_t[on_chan(s.ptr)][15:8] = s.shreg;
              end
            end else if (cur_hit(s.ptr)) begin
              n.cur[4'(s.ptr - REG_CUR_BASE)] = s.shreg[CUR_W-1:0];
            end else begin
              case (s.ptr)
                REG_EN_LO:   n.en_lo = s.shreg;
                REG_EN_HI:   n.en_hi = s.shreg;
                REG_DITHER:  n.dith = s.shreg;
                REG_PER_LO:  n.per_lo = s.shreg;
                REG_PER_HI:  n.per_hi = s.shreg;
                REG_JOIN_LO: n.join_lo = s.shreg;
                REG_JOIN_HI: n.join_hi = s.shreg;
                default:     n.ptr = s.ptr + 8'h01;
              endcase
            end
          end
        end
        I_RD: begin
          if (s.bitcnt == 4'h8) begin
            n.sda_oe = 1'b0;
            n.ist = I_RACK;
          end else begin
            n.shreg = {s.shreg[6:0], 1'b0};
            n.sda_oe = ~s.shreg[6];
          end
        end
        I_RACK: begin
          n.ptr = s.ptr + 8'h01;
          rd_byte = reg_read(s, s.ptr + 8'h01);
          n.shreg = rd_byte;
          n.sda_oe = ~rd_byte[7];
          n.bitcnt = '0;
          n.ist = I_RD;
        end
        default: n.ist = I_IDLE;
      endcase
    end

    // 0.15 us step from a fractional accumulator, since 150 ns is not a whole clock count
    n.step = 1'b0;
    n.wrap = 1'b0;
    if (s.acc + 8'(CLK_PERIOD_NS) >= 8'(ON_STEP_NS)) begin
      n.acc = s.acc + 8'(CLK_PERIOD_NS) - 8'(ON_STEP_NS);
      n.step = 1'b1;
    end else begin
      n.acc = s.acc + 8'(CLK_PERIOD_NS);
    end

    slot = {4'h0, s.sh_per} + 17'h00001;
    frame_len = 17'(slot * 17'(FRAME_UNIT_STEPS));
    if (s.step) begin
      if (s.cnt >= frame_len - 17'h00001) begin
        n.cnt = '0;
        n.wrap = 1'b1;
        n.sh_per = {s.per_hi[PER_HI_BITS-1:0], s.per_lo};
        n.sh_on = s.on_t;
        n.sh_en = {s.en_hi[HI_BITS-1:0], s.en_lo};
        n.sh_join = {s.join_hi[HI_BITS-1:0], s.join_lo[7:1], 1'b0};
      end else begin
        n.cnt = s.cnt + 17'h00001;
      end
    end

    // each channel follows the lowest member of its group; its slot starts at the leader's index times the slot width
    for (int k = 0; k < CHANNELS; k++) begin
      lead[k] = (k > 0 && s.sh_join[k]) ? lead[k-1] : 4'(k);
      start_k = 17'(17'(lead[k]) * slot);
      diff = (s.cnt >= start_k) ? s.cnt - start_k : s.cnt + frame_len - start_k;
      eff_on = (s.sh_on[lead[k]] < 16'(MIN_ON_STEPS)) ? 17'(MIN_ON_STEPS) : {1'b0, s.sh_on[lead[k]]};
      n.sink[k] = s.sh_en[lead[k]] && s.sh_en[k] && (diff < eff_on);
    end

    // dither engine
    n.fsy = {s.fsy[1:0], freq_set_sync_pin_in};
    n.osc = {s.osc[1:0], sw_osc_in};
    osc_rise = s.osc[1] & ~s.osc[2];
    if (s.fsy[1] ^ s.fsy[2]) begin
      n.sync_cnt = 10'(SYNC_LOSS_CYC);
    end else if (s.sync_cnt != '0) begin
      n.sync_cnt = s.sync_cnt - 10'h001;
    end
    n.adv = 1'b0;
    if (osc_rise) begin
      n.half = ~s.half;
      if (s.half) begin
        n.adv = 1'b1;
        n.idx = (s.idx == 6'(DITHER_LEN - 1)) ? 6'h00 : s.idx + 6'h01;
      end
    end
    n.dith_o.active = (s.dith[SPREAD_W-1:0] != '0) && (s.sync_cnt == '0);
    n.dith_o.spread_index_field = n.dith_o.active ? s.dith[SPREAD_W-1:0] : '0;
    n.dith_o.high = n.dith_o.active && DITHER_PATTERN[s.idx];
  end

  // =====================================================================
  // state register
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      s <= STATE_RST;
    end else begin
      s <= n;
    end
  end

  assign sda_out             = s.sda_lvl;
  assign sda_oe_out          = s.sda_oe;
  assign string_sink_pin_out = s.sink;
  assign sink_current_out    = s.cur;
  assign dither_out          = s.dith_o;

  // =====================================================================
  // checks
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_n);

  property p_min_pulse;
    $rose(s.sink[0]) |-> ##129 s.sink[0];
  endproperty
  a_min_pulse: assert property (p_min_pulse) else $error("channel pulse shorter than minimum");

  property p_pattern_len;
    s.idx < 6'(DITHER_LEN);
  endproperty
  a_pattern_len: assert property (p_pattern_len) else $error("dither index out of pattern");

  property p_sync_blocks;
    (s.sync_cnt != '0) |=> !s.dith_o.active;
  endproperty
  a_sync_blocks: assert property (p_sync_blocks) else $error("dither active during external sync");

  property p_zero_off;
    (s.dith[SPREAD_W-1:0] == '0) |=> !s.dith_o.active && s.dith_o.spread_index_field == '0;
  endproperty
  a_zero_off: assert property (p_zero_off) else $error("dither not off for zero field");

  property p_level_pace;
    $changed(s.idx) |-> s.adv && $past(s.half);
  endproperty
  a_level_pace: assert property (p_level_pace) else $error("dither level moved off two-cycle pace");

  property p_frame_bound;
    s.cnt < frame_len;
  endproperty
  a_frame_bound: assert property (p_frame_bound) else $error("tick counter beyond frame");

  property p_step_sparse;
    s.step |=> !s.step [*8];
  endproperty
  a_step_sparse: assert property (p_step_sparse) else $error("on-time steps too close");

  property p_latch_at_wrap;
    $changed(s.sh_per) |-> s.wrap;
  endproperty
  a_latch_at_wrap: assert property (p_latch_at_wrap) else $error("period taken mid frame");

  property p_leader_off;
    (s.sh_join[3] && !s.sh_join[2] && !s.sh_en[2]) |=> !s.sink[3];
  endproperty
  a_leader_off: assert property (p_leader_off) else $error("group member on with leader disabled");

  property p_group_together;
    (s.sh_join[1] && s.sh_en[1] && $stable(s.sh_en)) |=> s.sink[1] == s.sink[0];
  endproperty
  a_group_together: assert property (p_group_together) else $error("grouped channels differ");

  c_group_on:   cover property (s.sh_join[1] && $rose(s.sink[1]));
  c_dither_hi:  cover property (s.dith_o.active && $rose(s.dith_o.high));
  c_bus_write:  cover property (s.ist == I_ACKW);
  c_last_slot:  cover property ($rose(s.sink[CHANNELS-1]));

endmodule

//--- dv/serial_host_model.sv
// =====================================================================
// two-wire bus host, open drain: sda_pull_out high pulls the line low
module serial_host_model
  import dimming_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_pull_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // quarter bit of 8 clocks keeps every scl phase well above the 4-clock floor
  localparam int Q = 8;

  initial begin
    scl_out = 1'b1;
    sda_pull_out = 1'b0;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  task automatic bit_out(input logic b);
    wt(Q);
    sda_pull_out <= ~b;
    wt(Q);
    scl_out <= 1'b1;
    wt(2 * Q);
    scl_out <= 1'b0;
  endtask

  task automatic bit_in(output logic b);
    wt(Q);
    sda_pull_out <= 1'b0;
    wt(Q);
    scl_out <= 1'b1;
    wt(Q);
    b = sda_in;
    wt(Q);
    scl_out <= 1'b0;
  endtask

  task automatic start_c();
    wt(Q);
    sda_pull_out <= 1'b0;
    scl_out <= 1'b1;
    wt(Q);
    sda_pull_out <= 1'b1;
    wt(Q);
    scl_out <= 1'b0;
  endtask

  task automatic stop_c();
    wt(Q);
    sda_pull_out <= 1'b1;
    wt(Q);
    scl_out <= 1'b1;
    wt(Q);
    sda_pull_out <= 1'b0;
    wt(Q);
  endtask

  task automatic byte_out(input logic [7:0] d, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) bit_out(d[i]);
    bit_in(a);
    ack = ~a;
  endtask

  task automatic byte_in(input logic last, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) bit_in(d[i]);
    bit_out(last);
  endtask

  // no need to stop dimming before any write, the period included
  task automatic write(input logic [6:0] a, input logic [7:0] r, input logic [15:0] d, input int n,
                       output logic ok);
    logic k;
    start_c();
    byte_out({a, 1'b0}, ok);
    if (ok) begin
      byte_out(r, k);
      ok = ok & k;
      for (int i = n - 1; i >= 0; i--) begin
        byte_out(d[8*i+:8], k);
        ok = ok & k;
      end
    end
    stop_c();
  endtask

  task automatic read(input logic [7:0] r, output logic [7:0] d, output logic ok);
    logic k;
    start_c();
    byte_out({DEV_ADDR, 1'b0}, ok);
    byte_out(r, k);
    ok = ok & k;
    stop_c();
    start_c();
    byte_out({DEV_ADDR, 1'b1}, k);
    ok = ok & k;
    byte_in(1'b1, d);
    stop_c();
  endtask
endmodule

//--- dv/testbench.sv
module testbench
  import dimming_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int FRM = 750;

  logic                core_clk;
  logic                reset_n;
  logic                scl;
  logic                sda_pull;
  logic                sw_osc;
  logic                sync_pin;
  logic                sda_o;
  logic                sda_oe;
  wire logic           sda_line;
  logic [CHANNELS-1:0] sink;
  logic [CHANNELS-1:0] sink_q;
  current_t            cur;
  dither_s             dith;
  int                  num_errors = 0;
  int                  num_checks = 0;
  int                  cyc = 0;
  int                  rise_t[CHANNELS];
  int                  width[CHANNELS];
  int                  per[CHANNELS];
  int                  rises[CHANNELS];
  logic                h[96];

  // pull-up: the line is high unless one party pulls it low
  assign sda_line = ~sda_pull & ~(sda_oe & ~sda_o);

  polyphase_dimming DUT (
    .core_clk_in          (core_clk),
    .reset_n_in           (reset_n),
    .scl_in               (scl),
    .sda_in               (sda_line),
    .sda_out              (sda_o),
    .sda_oe_out           (sda_oe),
    .freq_set_sync_pin_in (sync_pin),
    .sw_osc_in            (sw_osc),
    .string_sink_pin_out  (sink),
    .sink_current_out     (cur),
    .dither_out           (dith)
  );

  serial_host_model host (
    .clk_in       (core_clk),
    .sda_in       (sda_line),
    .scl_out      (scl),
    .sda_pull_out (sda_pull)
  );

  // =====================================================================
  // clocks and pulse monitor
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // 496 ns switching cycle, near 2 MHz
  initial begin
    sw_osc = 1'b0;
    forever begin
      repeat (31) @(posedge core_clk);
      sw_osc <= ~sw_osc;
    end
  end

  always @(posedge core_clk) begin
    cyc++;
    for (int k = 0; k < CHANNELS; k++) begin
      if (sink[k] === 1'b1 && sink_q[k] === 1'b0) begin
        per[k] = cyc - rise_t[k];
        rise_t[k] = cyc;
        rises[k]++;
      end
      if (sink[k] === 1'b0 && sink_q[k] === 1'b1) width[k] = cyc - rise_t[k];
    end
    sink_q = sink;
  end

  // =====================================================================
  // checks and bus helpers
  task automatic end_of_test();
    if (num_errors == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // two-clock slack for the fractional 18/19-clock step
  task automatic near(input int got, input int exp);
    num_checks++;
    if (got < exp - 2 || got > exp + 2) begin
      num_errors++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  function automatic int off(input int k, input int j);
    int d;
    d = ((rise_t[k] - rise_t[j]) % FRM + FRM) % FRM;
    if (d > 700) d -= FRM;
    return d;
  endfunction

  task automatic wr(input logic [7:0] r, input logic [15:0] d, input int n);
    logic ok;
    host.write(DEV_ADDR, r, d, n, ok);
    chk(32'(ok), 32'h1);
  endtask

  task automatic rd_chk(input logic [7:0] r, input logic [7:0] exp);
    logic [7:0] d;
    logic       ok;
    host.read(r, d, ok);
    chk(32'(ok), 32'h1);
    chk(32'(d), 32'(exp));
  endtask

  // settings land at a frame wrap, so let old frames pass before counting
  task automatic measure();
    repeat (2300) @(posedge core_clk);
    rises = '{default: 0};
    repeat (1600) @(posedge core_clk);
  endtask

  initial begin
    repeat (90000) @(posedge core_clk);
    num_errors++;
    end_of_test();
  end

  // =====================================================================
  // main sequence
  initial begin
    logic ok;
    int   e0;
    int   e1;
    int   hit;
    reset_n = 1'b0;
    sync_pin = 1'b0;
    sink_q = '0;
    rise_t = '{default: 0};
    width = '{default: 0};
    per = '{default: 0};
    rises = '{default: 0};
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (10) @(posedge core_clk);
    rd_chk(REG_EN_LO, 8'h00);
    rd_chk(REG_DITHER, 8'h00);
    host.write(DEV_ADDR ^ 7'h01, 8'h00, 16'h00FF, 1, ok);
    chk(32'(ok), 32'h0);
    wr(8'h04, 16'h00FF, 1);
    rd_chk(REG_DITHER, 8'h00);
    // on-times: ch0 20 steps, ch1 1 step, ch3 30 steps, rest 8 steps
    for (int k = 0; k < CHANNELS; k++)
      wr(REG_ON_FIRST + 8'(2 * k), k == 0 ? 16'h0014 : k == 1 ? 16'h0001 : k == 3 ? 16'h001E : 16'h0008, 2);
    rd_chk(8'h11, 8'h14);
    for (int k = 0; k < CHANNELS; k++) wr(REG_CUR_BASE + 8'(k), k == 9 ? 16'h3F : 16'(5 * k), 1);
    wr(REG_EN_LO, 16'h00FF, 1);
    wr(REG_EN_HI, 16'h0003, 1);
    rd_chk(REG_EN_HI, 8'h03);
    wr(REG_PER_LO, 16'h0300, 2);
    rd_chk(REG_PER_LO, 8'h03);
    measure();
    near(per[0], FRM);
    for (int k = 1; k < CHANNELS; k++) near(off(k, 0), 75 * k);
    near(width[0], 375);
    near(width[1], 131);
    near(width[5], 150);
    // join 1 to 0, and 3, 4 to 2; member 4 switched off
    wr(REG_JOIN_LO, 16'h001A, 1);
    rd_chk(REG_JOIN_LO, 8'h1A);
    wr(REG_EN_LO, 16'h00EF, 1);
    measure();
    near(off(1, 0), 0);
    near(width[1], 375);
    near(off(3, 2), 0);
    near(width[3], 150);
    chk(32'(rises[4]), 32'h0);
    near(off(5, 0), 375);
    for (int k = 0; k < CHANNELS; k++) chk(32'(cur[k]), k == 9 ? 32'h3F : 32'(5 * k));
    wr(REG_EN_LO, 16'h00EB, 1);
    measure();
    chk(32'(rises[2] + rises[3]), 32'h0);
    near(off(5, 0), 375);
    for (int c = 0; c < 4; c++) begin
      wr(REG_DITHER, 16'(c), 1);
      repeat (200) @(posedge core_clk);
      chk(32'(dith.active), c != 0);
      chk(32'(dith.spread_index_field), 32'(c));
    end
    // external sync edges hold dithering off until 6 us after the last one
    for (int i = 0; i < 30; i++) begin
      repeat (40) @(posedge core_clk);
      sync_pin <= ~sync_pin;
    end
    repeat (20) @(posedge core_clk);
    chk(32'(dith.active), 32'h0);
    repeat (900) @(posedge core_clk);
    chk(32'(dith.active), 32'h1);
    // the oscillator has a fixed 62-clock period from time zero: sample ten clocks past its rise
    for (int i = 0; i < 62 && cyc % 62 != 41; i++) @(posedge core_clk);
    for (int i = 0; i < 96; i++) begin
      h[i] = dith.high;
      repeat (62) @(posedge core_clk);
    end
    e0 = 0;
    e1 = 0;
    for (int i = 0; i < 94; i += 2) begin
      e0 += int'(h[i] !== h[i+1]);
      e1 += int'(h[i+1] !== h[i+2]);
    end
    chk(32'(e0 == 0 || e1 == 0), 32'h1);
    hit = 0;
    for (int s = 0; s < DITHER_LEN; s++) begin
      ok = 1'b1;
      for (int j = 0; j < DITHER_LEN; j++)
        if (h[2 * j + (e0 == 0 ? 0 : 1)] !== DITHER_PATTERN[(s + j) % DITHER_LEN]) ok = 1'b0;
      hit += int'(ok);
    end
    chk(32'(hit > 0), 32'h1);
    end_of_test();
  end
endmodule
